// ### design/i2csf_evt_if.sv
// Interface carrying bus-engine events into the flag block.
// Assumes the shift engine pulses each event for one clk cycle.
`timescale 1ns/100ps
`default_nettype none
interface i2csf_evt_if;
  logic       start_det;
  logic       stop_det;
  logic       addr_done;
  logic       addr_rw;
  logic       rx_done;
  logic [7:0] rx_byte;
  logic       tx_done;

  modport src (output start_det, stop_det, addr_done, addr_rw,
               output rx_done, rx_byte, tx_done);
  modport dst (input  start_det, stop_det, addr_done, addr_rw,
               input  rx_done, rx_byte, tx_done);
endinterface
`default_nettype wire

// ### design/i2csf_evt_reg.sv
// Registers the raw engine events into the carrier interface.
// Assumes synchronous single-cycle pulses on the inputs.
`timescale 1ns/100ps
`default_nettype none
module i2csf_evt_reg (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       start_i,
  input  wire logic       stop_i,
  input  wire logic       addr_done_i,
  input  wire logic       addr_rw_i,
  input  wire logic       rx_done_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       tx_done_i,
  i2csf_evt_if.src        ev
);
  // ==========================================================
  // One stage of registering, so flags settle one cycle later
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev.start_det <= 1'b0;
      ev.stop_det  <= 1'b0;
      ev.addr_done <= 1'b0;
      ev.addr_rw   <= 1'b0;
      ev.rx_done   <= 1'b0;
      ev.rx_byte   <= i2csf_pkg::RST_BYTE;
      ev.tx_done   <= 1'b0;
    end else begin
      ev.start_det <= start_i;
      ev.stop_det  <= stop_i;
      ev.addr_done <= addr_done_i;
      ev.addr_rw   <= addr_rw_i;
      ev.rx_done   <= rx_done_i;
      ev.rx_byte   <= rx_byte_i;
      ev.tx_done   <= tx_done_i;
    end
  end
endmodule // i2csf_evt_reg
`default_nettype wire

// ### design/i2csf_pkg.sv
// Package for the two-wire status flag block: offsets, fields, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
package i2csf_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_BUS_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RX_HOLD    = 8'h04;
  localparam logic [7:0] ADDR_TX_HOLD    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

  // ==========================================================
  // Bus status field positions
  localparam int BIT_TX_FULL   = 0;
  localparam int BIT_RX_FULL   = 1;
  localparam int BIT_DIR       = 2;
  localparam int BIT_START     = 3;
  localparam int STATUS_W      = 16;

  // ==========================================================
  // Event bits in interrupt status
  localparam int EV_START  = 0;
  localparam int EV_STOP   = 1;
  localparam int EV_ADDR   = 2;
  localparam int EV_RXFULL = 3;
  localparam int EV_TXDONE = 4;
  localparam int EV_W      = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0]      RST_BYTE = 8'h00;
  localparam logic [EV_W-1:0] RST_EV   = 5'h00;
  localparam logic [31:0]     RD_ZERO  = 32'h0000_0000;

endpackage

// ### design/i2csf_top.sv
// Status flags of a two-wire serial controller with APB registers.
// Assumes engine events synchronous to clk_sys_i, one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module i2csf_top (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        start_det_i,
  input  wire logic        stop_det_i,
  input  wire logic        addr_done_i,
  input  wire logic        addr_rw_i,
  input  wire logic        rx_done_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        tx_done_i,
  output logic [7:0]       tx_byte_o,
  output logic             tx_load_o,
  output logic             irq_o
);

  // ==========================================================
  // Event carrier
  i2csf_evt_if ev ();

  i2csf_evt_reg u_evt (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .start_i     (start_det_i),
    .stop_i      (stop_det_i),
    .addr_done_i (addr_done_i),
    .addr_rw_i   (addr_rw_i),
    .rx_done_i   (rx_done_i),
    .rx_byte_i   (rx_byte_i),
    .tx_done_i   (tx_done_i),
    .ev          (ev)
  );

  // ==========================================================
  // APB decode
  logic                        acc;
  logic                        wr;
  logic                        rd;
  logic                        mapped;
  logic                        start_q;
  logic                        dir_q;
  logic                        rxf_q;
  logic                        txf_q;
  logic [7:0]                  rx_hold_q;
  logic [7:0]                  tx_hold_q;
  logic [i2csf_pkg::EV_W-1:0]  ev_q;
  logic [i2csf_pkg::EV_W-1:0]  en_q;
  logic [i2csf_pkg::EV_W-1:0]  ev_set;
  logic [i2csf_pkg::EV_W-1:0]  ev_clr;
  logic [31:0]                 rdata_d;

  // Zero-wait slave: access phase completes in its first cycle
  assign acc = psel_i & penable_i;
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;

  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      i2csf_pkg::ADDR_BUS_STATUS,
      i2csf_pkg::ADDR_RX_HOLD,
      i2csf_pkg::ADDR_TX_HOLD,
      i2csf_pkg::ADDR_IRQ_STATUS,
      i2csf_pkg::ADDR_IRQ_CLEAR,
      i2csf_pkg::ADDR_IRQ_ENABLE: mapped = 1'b1;
      default:                    mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
    end
  end

  // ==========================================================
  // Start flag: Stop clears, Start or Restart sets
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_q <= 1'b0;
    end else if (ev.start_det) begin
      start_q <= 1'b1;
    end else if (ev.stop_det) begin
      start_q <= 1'b0;
    end
  end

  // ==========================================================
  // Direction flag, only meaningful in slave operation
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_q <= 1'b0;
    end else if (ev.addr_done) begin
      dir_q <= ev.addr_rw;
    end
  end

  // ==========================================================
  // Receive holding register and full flag; set wins over read
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_hold_q <= i2csf_pkg::RST_BYTE;
    end else if (ev.rx_done) begin
      rx_hold_q <= ev.rx_byte;
    end
  end

  // Completes on the access edge; pready high in that cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rxf_q <= 1'b0;
    end else if (ev.rx_done) begin
      rxf_q <= 1'b1;
    end else if (rd && pready_o && paddr_i == i2csf_pkg::ADDR_RX_HOLD) begin
      rxf_q <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit holding register and full flag; write wins over done
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_hold_q <= i2csf_pkg::RST_BYTE;
      tx_load_o <= 1'b0;
    end else begin
      tx_load_o <= 1'b0;
      if (wr && pready_o && paddr_i == i2csf_pkg::ADDR_TX_HOLD) begin
        tx_hold_q <= pwdata_i[7:0];
        tx_load_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txf_q <= 1'b0;
    end else if (wr && pready_o && paddr_i == i2csf_pkg::ADDR_TX_HOLD) begin
      txf_q <= 1'b1;
    end else if (ev.tx_done) begin
      txf_q <= 1'b0;
    end
  end

  assign tx_byte_o = tx_hold_q;

  // ==========================================================
  // Interrupt status: sticky, write-one-to-clear, set wins
  always_comb begin
    ev_set = '0;
    ev_set[i2csf_pkg::EV_START]  = ev.start_det;
    ev_set[i2csf_pkg::EV_STOP]   = ev.stop_det;
    ev_set[i2csf_pkg::EV_ADDR]   = ev.addr_done;
    ev_set[i2csf_pkg::EV_RXFULL] = ev.rx_done;
    ev_set[i2csf_pkg::EV_TXDONE] = ev.tx_done;
    ev_clr = '0;
    if (wr && pready_o && paddr_i == i2csf_pkg::ADDR_IRQ_CLEAR) begin
      ev_clr = pwdata_i[i2csf_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_q <= i2csf_pkg::RST_EV;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= i2csf_pkg::RST_EV;
    end else if (wr && pready_o && paddr_i == i2csf_pkg::ADDR_IRQ_ENABLE) begin
      en_q <= pwdata_i[i2csf_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((ev_q & ~ev_clr) | ev_set) & en_q);
    end
  end

  // ==========================================================
  // Read mux; bus status ignores writes entirely
  always_comb begin
    rdata_d = i2csf_pkg::RD_ZERO;
    case (paddr_i)
      i2csf_pkg::ADDR_BUS_STATUS: begin
        rdata_d[i2csf_pkg::BIT_START]   = start_q;
        rdata_d[i2csf_pkg::BIT_DIR]     = dir_q;
        rdata_d[i2csf_pkg::BIT_RX_FULL] = rxf_q;
        rdata_d[i2csf_pkg::BIT_TX_FULL] = txf_q;
      end
      i2csf_pkg::ADDR_RX_HOLD:    rdata_d[7:0] = rx_hold_q;
      i2csf_pkg::ADDR_TX_HOLD:    rdata_d[7:0] = tx_hold_q;
      i2csf_pkg::ADDR_IRQ_STATUS: rdata_d[i2csf_pkg::EV_W-1:0] = ev_q;
      i2csf_pkg::ADDR_IRQ_ENABLE: rdata_d[i2csf_pkg::EV_W-1:0] = en_q;
      default:                    rdata_d = i2csf_pkg::RD_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= i2csf_pkg::RD_ZERO;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rdata_d;
    end
  end

  // ==========================================================
  // Checks
  logic                        tx_wr_acc;
  logic                        rx_rd_acc;
  assign tx_wr_acc = wr & pready_o & (paddr_i == i2csf_pkg::ADDR_TX_HOLD);
  assign rx_rd_acc = rd & pready_o & (paddr_i == i2csf_pkg::ADDR_RX_HOLD);

  // ==========================================================
  // Paths from a pin pulse or a bus setup onward
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_start_pin;
    start_det_i ##1 ev.start_det;
  endsequence
  sequence s_addr_pin;
    addr_done_i ##1 ev.addr_done;
  endsequence
  sequence s_rx_pin;
    rx_done_i ##1 ev.rx_done;
  endsequence
  sequence s_rx_read;
    s_setup ##1 (rx_rd_acc && !ev.rx_done);
  endsequence
  sequence s_tx_write;
    s_setup ##1 tx_wr_acc;
  endsequence
  sequence s_tx_done_pin;
    tx_done_i ##1 (ev.tx_done && !tx_wr_acc);
  endsequence

  a_start_set: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) ev.start_det |=> start_q)
    else $error("start flag not set");
  a_stop_clear: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ev.stop_det && !ev.start_det |=> !start_q)
    else $error("stop did not clear start flag");
  a_dir_read: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ev.addr_done && ev.addr_rw |=> dir_q)
    else $error("direction not read");
  a_dir_hold: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !ev.addr_done |=> $stable(dir_q))
    else $error("direction changed without address");
  a_rx_set: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ev.rx_done |=> rxf_q && rx_hold_q == $past(ev.rx_byte))
    else $error("receive full not set");
  a_rx_clear: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    rd && pready_o && paddr_i == i2csf_pkg::ADDR_RX_HOLD && !ev.rx_done
    |=> !rxf_q)
    else $error("receive read did not clear");
  a_tx_set: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    wr && pready_o && paddr_i == i2csf_pkg::ADDR_TX_HOLD
    |=> txf_q && tx_load_o)
    else $error("transmit full not set");
  a_tx_clear: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ev.tx_done && !(wr && paddr_i == i2csf_pkg::ADDR_TX_HOLD)
    |=> !txf_q)
    else $error("transmit done did not clear");
  a_status_ro: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    wr && paddr_i == i2csf_pkg::ADDR_BUS_STATUS && !ev.start_det
    && !ev.stop_det |=> $stable(start_q))
    else $error("status write changed flag");
  a_start_path: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) s_start_pin |=> start_q)
    else $error("start pulse did not reach flag");
  a_stop_path: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    stop_det_i && !start_det_i ##1 ev.stop_det |=> !start_q)
    else $error("stop pulse did not clear flag");
  a_dir_write: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ev.addr_done && !ev.addr_rw |=> !dir_q)
    else $error("direction not write");
  a_dir_path: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    s_addr_pin |=> dir_q == $past(addr_rw_i, 2))
    else $error("direction not taken from address byte");
  a_rx_path: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    s_rx_pin |=> rxf_q && rx_hold_q == $past(rx_byte_i, 2))
    else $error("received byte not held");
  a_rx_read: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) s_rx_read |=> !rxf_q)
    else $error("receive hold read left flag set");
  a_rx_keep: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !ev.rx_done && !rx_rd_acc |=> $stable(rxf_q))
    else $error("receive full changed without cause");
  a_tx_write: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    s_tx_write |=> txf_q && tx_byte_o == $past(pwdata_i[7:0]))
    else $error("transmit hold write not taken");
  a_tx_path: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) s_tx_done_pin |=> !txf_q)
    else $error("transmit done pulse did not clear");
  a_tx_keep: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !ev.tx_done && !tx_wr_acc |=> $stable(txf_q))
    else $error("transmit full changed without cause");
  a_ready_setup: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) s_setup |=> pready_o)
    else $error("ready missing in access cycle");
  a_ready_pulse: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    psel_i && !penable_i && !mapped |=> pslverr_o)
    else $error("unmapped access without error");
  a_load_pulse: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) tx_load_o |=> !tx_load_o)
    else $error("transmit load longer than one cycle");
  a_irq_off: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i) !(|en_q) |=> !irq_o)
    else $error("interrupt raised with nothing enabled");

endmodule // i2csf_top
`default_nettype wire

// ### test/i2c_status_flags_tb.sv
// Self-checking bench for the two-wire status flag block.
// Assumes the design files and the bus model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module i2c_status_flags_tb;
  logic        clk_sys_i, nrst_i, psel, penable, pwrite;
  logic [7:0]  paddr, gap;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, st, sp, ad, rw, rx, txd, txl, irq, er;
  logic [7:0]  rxb, txb;
  int          errors, total_checks, cyc;

  i2csf_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .start_det_i(st), .stop_det_i(sp),
    .addr_done_i(ad), .addr_rw_i(rw), .rx_done_i(rx), .rx_byte_i(rxb),
    .tx_done_i(txd), .tx_byte_o(txb), .tx_load_o(txl), .irq_o(irq));
  i2csf_bus_model pm (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .tx_load_i(txl), .gap_i(gap), .start_o(st), .stop_o(sp), .addr_o(ad),
    .rw_o(rw), .rx_o(rx), .byte_o(rxb), .tx_done_o(txd));

  // ==========================================================
  // Clock, reset, timeout
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // APB master: hold request until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // No local limit: pready or the bench timeout ends this wait
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_cond();
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0000);
    pm.ev(0, 1'b0, 8'h00);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0008);
    pm.ev(1, 1'b0, 8'h00);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0000);
    pm.ev(0, 1'b0, 8'h00);
    pm.ev(0, 1'b0, 8'h00);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0008);
  endtask

  task automatic t_dir_rx();
    pm.ev(2, 1'b1, 8'h00);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_000C);
    pm.ev(2, 1'b0, 8'h00);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0008);
    pm.ev(3, 1'b0, 8'hA5);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_000A);
    rd_chk(i2csf_pkg::ADDR_RX_HOLD, 32'h0000_00A5);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0008);
    apb(1'b1, i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_FFFF);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0008);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
  endtask

  task automatic t_tx();
    gap <= 8'h08;
    apb(1'b1, i2csf_pkg::ADDR_TX_HOLD, 32'h0000_003C);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0009);
    chk({24'h0, txb}, 32'h0000_003C);
    rd_chk(i2csf_pkg::ADDR_TX_HOLD, 32'h0000_003C);
    while (txd !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    repeat (3) @(posedge clk_sys_i);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0008);
    pm.ev(1, 1'b0, 8'h00);
  endtask

  task automatic t_irq();
    rd_chk(i2csf_pkg::ADDR_IRQ_STATUS, 32'h0000_001F);
    apb(1'b1, i2csf_pkg::ADDR_IRQ_ENABLE, 32'h0000_0008);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, i2csf_pkg::ADDR_IRQ_CLEAR, 32'h0000_001F);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(i2csf_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    rd_chk(i2csf_pkg::ADDR_IRQ_ENABLE, 32'h0000_0008);
    rd_chk(i2csf_pkg::ADDR_IRQ_CLEAR, 32'h0000_0000);
    rd_chk(i2csf_pkg::ADDR_BUS_STATUS, 32'h0000_0000);
  endtask

  initial begin
    errors = 0;
    total_checks = 0;
    cyc = 0;
    nrst_i = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    gap = 8'h04;
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_cond();
    t_dir_rx();
    t_tx();
    t_irq();
    tally_and_finish();
  end
endmodule // i2c_status_flags_tb
`default_nettype wire

// ### test/i2csf_bus_model.sv
// Behavioural far side: the bus engine that reports conditions and bytes.
// Assumes the bench calls ev() and sets gap_i before any transmit write.
`timescale 1ns/100ps
`default_nettype none
module i2csf_bus_model (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       tx_load_i,
  input  wire logic [7:0] gap_i,
  output logic            start_o,
  output logic            stop_o,
  output logic            addr_o,
  output logic            rw_o,
  output logic            rx_o,
  output logic [7:0]      byte_o,
  output logic            tx_done_o
);
  logic [7:0] cnt_q;

  initial begin
    start_o = 1'b0;
    stop_o  = 1'b0;
    addr_o  = 1'b0;
    rx_o    = 1'b0;
    rw_o    = 1'b1;
    byte_o  = 8'h5A;
  end

  // ==========================================================
  // One event pulse; qualifiers go stale (inverted) afterwards
  task automatic ev(input int k, input logic b, input logic [7:0] d);
    @(posedge clk_sys_i);
    case (k)
      0: start_o <= 1'b1;
      1: stop_o <= 1'b1;
      2: begin
        addr_o <= 1'b1;
        rw_o   <= b;
      end
      default: begin
        rx_o   <= 1'b1;
        byte_o <= d;
      end
    endcase
    @(posedge clk_sys_i);
    start_o <= 1'b0;
    stop_o  <= 1'b0;
    addr_o  <= 1'b0;
    rx_o    <= 1'b0;
    rw_o    <= ~b;
    byte_o  <= ~d;
    // Let the two-stage flag path settle before software looks
    repeat (2) @(posedge clk_sys_i);
  endtask

  // ==========================================================
  // Shift-out delay, then report completion once
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q     <= 8'h00;
      tx_done_o <= 1'b0;
    end else begin
      tx_done_o <= 1'b0;
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) tx_done_o <= 1'b1;
      end else if (tx_load_i) begin
        cnt_q <= gap_i;
      end
    end
  end
endmodule // i2csf_bus_model
`default_nettype wire
